// *** tb/pin_mux_props.sv ***
// Checker for the pin multiplexer, bound to its top module.
// Assumes one clock domain and async active-low reset.
`timescale 1ns/1ps
module pin_mux_props
    import pin_mux_pkg::*;
#(
    parameter int START_CYC = 50
) (
    // Clock and reset
    input wire logic                    ref_clk,
    input wire logic                    rstn,
    // Configuration side
    input wire logic                    cfgLoad,
    input wire logic [4:0]              cfgCombo,
    input wire logic                    cfgStartWinEn,
    input wire logic [15:0]             cfgSignature,
    input wire logic [15:0]             calcSignature,
    input wire logic                    regParityErr,
    input wire logic                    i2cSdaOe,
    // Observed outputs
    input wire pin_mux_pkg::pin_drive_t pins,
    input wire logic [14:0]             analogLevel,
    input wire logic                    ctrlErrorFlag,
    input wire logic [7:0]              serialErrCode,
    input wire logic                    oneWireMode
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic sigOk;
    logic okCombo;
    // =====
    // Load qualifiers
    assign sigOk   = (cfgSignature == calcSignature);
    assign okCombo = (cfgCombo >= COMBO_MIN) && (cfgCombo <= COMBO_MAX);
    sequence loadClean;
        cfgLoad && !ctrlErrorFlag && !regParityErr;
    endsequence
    // Quiet span after a load, long enough for the pin register
    sequence settle;
        ##1 (!cfgLoad && !regParityErr && !ctrlErrorFlag) [*3];
    endsequence
    // =====
    // Properties
    a_error_sticky: assert property (ctrlErrorFlag |=> ctrlErrorFlag)
        else $error("error flag dropped without reset");
    a_parity_flag: assert property (regParityErr |-> ##[1:3] ctrlErrorFlag)
        else $error("parity error not flagged");
    a_parity_min: assert property (regParityErr && !ctrlErrorFlag
        |-> ##[1:3] analogLevel == ANA_MIN) else $error("parity level not minimum");
    a_bad_combo: assert property (loadClean ##0 (sigOk && !okCombo)
        |-> ##[1:3] serialErrCode == ERR_COMBO) else $error("bad combination accepted");
    a_sig_error: assert property (loadClean ##0 (!sigOk && okCombo)
        |-> ##[1:3] (serialErrCode == ERR_SIGNATURE && analogLevel == ANA_MAX))
        else $error("signature mismatch not diagnosed");
    a_spi_select: assert property (loadClean ##0 (sigOk && okCombo
        && cfgCombo > COMBO_I2C_MAX) ##0 settle |-> !pins.auxSecondOe)
        else $error("second aux pin driven under SPI");
    a_i2c_sda: assert property (loadClean ##0 (sigOk && okCombo && !cfgStartWinEn
        && cfgCombo <= COMBO_I2C_MAX) ##0 settle |-> pins.dataOe == $past(i2cSdaOe))
        else $error("data pin enable not following I2C core");
    a_window_hold: assert property ($rose(oneWireMode) |-> oneWireMode [*8])
        else $error("start window cut short");
endmodule

bind sensor_output_pin_mux pin_mux_props #(.START_CYC(START_CYC)) i_pin_mux_props (
    .ref_clk(ref_clk), .rstn(rstn), .cfgLoad(cfgLoad), .cfgCombo(cfgCombo),
    .cfgStartWinEn(cfgStartWinEn), .cfgSignature(cfgSignature),
    .calcSignature(calcSignature), .regParityErr(regParityErr), .i2cSdaOe(i2cSdaOe),
    .pins(pins), .analogLevel(analogLevel), .ctrlErrorFlag(ctrlErrorFlag),
    .serialErrCode(serialErrCode), .oneWireMode(oneWireMode));

// *** tb/serial_master_model.sv ***
// Far-side model: bus master pins and one-wire requester.
// Assumes the bench commands it through plain levels on ref_clk.
`timescale 1ns/1ps
module serial_master_model (
    // Clock
    input  wire logic ref_clk,
    // Bench commands
    input  wire logic selReq,
    input  wire logic bitReq,
    input  wire logic pulseReq,
    // Pin levels toward the device
    output logic      auxSecondIn = 1'b1,
    output logic      dataIn      = 1'b0,
    output logic      wireReqIn   = 1'b0
);
    // =====
    // Pin drive
    // Unselected data line toggles so a stale bit never looks valid
    always @(posedge ref_clk) begin
        auxSecondIn <= !selReq;
        dataIn      <= selReq ? bitReq : !dataIn;
        wireReqIn   <= pulseReq;
    end
endmodule

// *** tb/test_sensor_output_pin_mux.sv ***
// Self-checking bench for the sensor output pin multiplexer.
// Assumes the far-side model and the bound checker are compiled before it.
`timescale 1ns/1ps
module test_sensor_output_pin_mux;
    import pin_mux_pkg::*;
    localparam int WIN = 50;
    logic ref_clk = 0, rstn = 0, cfgLoad = 0, cfgStartWinEn = 0, regParityErr = 0;
    logic bridgeAlarmFirst = 0, bridgeAlarmSecond = 0, pulseFirst = 0, pulseSecond = 0;
    logic spiSdo = 0, i2cSdaOut = 0, i2cSdaOe = 0, command_mode = 0;
    logic selReq = 0, bitReq = 0, pulseReq = 0, auxSecondIn, dataIn, wireReqIn;
    logic [4:0] cfgCombo = 5'h00;
    logic [15:0] cfgSignature = 16'hA5A5, calcSignature = 16'hA5A5;
    // Stimulus words stay within the output width, below the converter's
    logic [14:0] bridgeVal = 15'h1234, temp1Val = 15'h2345, temp2Val = 15'h3456;
    src_sel_t analogSrc = SRC_BRIDGE;
    pin_drive_t pins;
    logic [14:0] analogLevel;
    logic [7:0] serialErrCode;
    logic ctrlErrorFlag, oneWireMode, spiSelectN, spiDataIn, normal_operation_mode;
    logic [4:0] badCombo [3] = '{5'h00, 5'h1C, 5'h1F};
    int fails = 0, n_tests = 0;

    always #10 ref_clk = ~ref_clk;

    sensor_output_pin_mux #(.START_CYC(WIN)) i_sensor_output_pin_mux (
        .ref_clk(ref_clk), .rstn(rstn), .cfgLoad(cfgLoad), .cfgCombo(cfgCombo),
        .cfgStartWinEn(cfgStartWinEn), .cfgSignature(cfgSignature),
        .calcSignature(calcSignature), .regParityErr(regParityErr), .bridgeVal(bridgeVal),
        .temp1Val(temp1Val), .temp2Val(temp2Val), .analogSrc(analogSrc),
        .bridgeAlarmFirst(bridgeAlarmFirst), .bridgeAlarmSecond(bridgeAlarmSecond),
        .pulseFirst(pulseFirst), .pulseSecond(pulseSecond), .spiSdo(spiSdo),
        .i2cSdaOut(i2cSdaOut), .i2cSdaOe(i2cSdaOe), .command_mode(command_mode),
        .auxSecondIn(auxSecondIn), .dataIn(dataIn), .wireReqIn(wireReqIn), .pins(pins),
        .analogLevel(analogLevel), .ctrlErrorFlag(ctrlErrorFlag),
        .serialErrCode(serialErrCode), .oneWireMode(oneWireMode), .spiSelectN(spiSelectN),
        .spiDataIn(spiDataIn), .normal_operation_mode(normal_operation_mode));

    serial_master_model i_serial_master_model (.ref_clk(ref_clk), .selReq(selReq),
        .bitReq(bitReq), .pulseReq(pulseReq), .auxSecondIn(auxSecondIn), .dataIn(dataIn),
        .wireReqIn(wireReqIn));

    // =====
    // Helpers
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Inputs always move the same small delay after an edge
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    // Fresh reset per load, since errors only clear on reset
    task automatic load(input logic [4:0] c, input logic win, input logic sig);
        rstn = 0;
        cfgStartWinEn = win;
        calcSignature = sig ? 16'hA5A5 : 16'h5A5A;
        tick(3);
        rstn = 1;
        tick(1);
        cfgLoad = 1;
        cfgCombo = c;
        tick(1);
        cfgLoad = 0;
        tick(3);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // =====
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (3000) @(posedge ref_clk);
        fails++;
        complete_run;
    end

    // =====
    // Tests
    initial begin
        i2cSdaOe = 1;
        i2cSdaOut = 1;
        load(5'h07, 0, 1);
        check("mainAnalogEn", pins.mainAnalogEn, 1'b1);
        check("analog bridge", analogLevel, bridgeVal);
        check("sda drive", {pins.dataOe, pins.dataOut}, 2'b11);
        analogSrc = SRC_TEMP2;
        i2cSdaOe = 0;
        cfgCombo = 5'h1C;
        tick(3);
        check("analog temp2", analogLevel, temp2Val);
        check("sda release", pins.dataOe, 1'b0);
        check("combo kept", {ctrlErrorFlag, pins.mainAnalogEn}, 2'b01);
        analogSrc = SRC_TEMP1;
        tick(2);
        check("analog temp1", analogLevel, temp1Val);
        analogSrc = SRC_BRIDGE;
        bridgeAlarmFirst = 1;
        bridgeAlarmSecond = 1;
        load(5'h04, 0, 1);
        check("alarm first", {pins.auxFirst, pins.auxFirstOe}, 2'b11);
        check("alarm second", {pins.auxSecond, pins.auxSecondOe}, 2'b11);
        bridgeAlarmFirst = 0;
        spiSdo = 1;
        selReq = 1;
        bitReq = 1;
        load(5'h13, 0, 1);
        check("sdo", {pins.auxFirst, pins.auxFirstOe}, 2'b11);
        check("no ss drive", {pins.auxSecondOe, pins.dataOe}, 2'b00);
        check("select in", {spiSelectN, spiDataIn}, 2'b01);
        selReq = 0;
        command_mode = 1;
        load(5'h14, 0, 1);
        check("cm sdo", pins.auxFirst, 1'b1);
        command_mode = 0;
        tick(3);
        check("nom alarm", {pins.auxFirst, normal_operation_mode}, 2'b01);
        pulseSecond = 1;
        command_mode = 1;
        load(5'h1A, 0, 1);
        check("pulse paused", pins.mainOe, 1'b0);
        command_mode = 0;
        tick(3);
        check("pulse on", {pins.mainOe, pins.mainPulse}, 2'b11);
        command_mode = 1;
        load(5'h19, 0, 1);
        check("shared pause", {pins.mainOe, pins.auxFirst}, 2'b01);
        command_mode = 0;
        tick(3);
        check("shared pulse", {pins.mainOe, pins.auxFirst}, 2'b11);
        for (int i = 0; i < 3; i++) begin
            load(badCombo[i], 0, 1);
            check("bad combo", {ctrlErrorFlag, serialErrCode}, {1'b1, ERR_COMBO});
        end
        load(5'h07, 0, 0);
        check("sig code", {ctrlErrorFlag, serialErrCode}, {1'b1, ERR_SIGNATURE});
        check("sig level", analogLevel, ANA_MAX);
        load(5'h07, 0, 1);
        regParityErr = 1;
        tick(1);
        regParityErr = 0;
        tick(3);
        check("parity code", {ctrlErrorFlag, serialErrCode}, {1'b1, ERR_PARITY});
        check("parity level", analogLevel, ANA_MIN);
        load(5'h07, 1, 1);
        check("window open", oneWireMode, 1'b1);
        tick(WIN);
        check("window over", {oneWireMode, pins.mainAnalogEn}, 2'b01);
        load(5'h07, 1, 1);
        pulseReq = 1;
        tick(3);
        pulseReq = 0;
        tick(WIN);
        check("request held", oneWireMode, 1'b1);
        complete_run;
    end
endmodule

// *** verilog/pin_mux_pkg.sv ***
// Package for the sensor output pin multiplexer.
// Assumes a single 50 MHz reference clock and active-low async reset.
package pin_mux_pkg;

    // ========================================================
    // Clock and timing
    localparam int CLK_HZ        = 50_000_000;
    localparam int START_WIN_MS  = 20;
    localparam int START_WIN_CYC = (START_WIN_MS * (CLK_HZ / 1000));

    // ========================================================
    // Combination numbering
    localparam logic [4:0] COMBO_MIN     = 5'h01;
    localparam logic [4:0] COMBO_MAX     = 5'h1B;
    localparam logic [4:0] COMBO_I2C_MAX = 5'h12;
    localparam logic [4:0] COMBO_RESET   = 5'h00;
    localparam int         COMBO_BITS    = 5;

    // ========================================================
    // Error codes presented on the serial output registers
    localparam logic [7:0] ERR_NONE      = 8'h00;
    localparam logic [7:0] ERR_SIGNATURE = 8'hE1;
    localparam logic [7:0] ERR_PARITY    = 8'hE2;
    localparam logic [7:0] ERR_COMBO     = 8'hE3;

    // Analog levels in diagnostic mode
    localparam logic [14:0] ANA_MAX = 15'h7FFF;
    localparam logic [14:0] ANA_MIN = 15'h0000;

    // ========================================================
    // Function selections per pin
    typedef enum logic [2:0] {
        FN_NONE   = 3'h0,
        FN_ANALOG = 3'h1,
        FN_PULSE  = 3'h2,
        FN_ALARM  = 3'h3,
        FN_SERIAL = 3'h4
    } pin_fn_t;

    // Value sources for the analog output
    typedef enum logic [1:0] {
        SRC_BRIDGE = 2'h0,
        SRC_TEMP1  = 2'h1,
        SRC_TEMP2  = 2'h2
    } src_sel_t;

    // System control states
    typedef enum logic [3:0] {
        ST_INIT  = 4'b0001,
        ST_START = 4'b0010,
        ST_RUN   = 4'b0100,
        ST_DIAG  = 4'b1000
    } sys_state_t;

    // Pin drive group
    typedef struct packed {
        logic mainAnalogEn;
        logic mainPulse;
        logic mainOe;
        logic auxFirst;
        logic auxFirstOe;
        logic auxSecond;
        logic auxSecondOe;
        logic dataOut;
        logic dataOe;
    } pin_drive_t;

    // Module state
    typedef struct packed {
        sys_state_t  state;
        logic [4:0]  combo;
        logic        wireMode;
        logic [20:0] winCnt;
        logic        ctrlError;
        logic [7:0]  errCode;
        logic [14:0] anaLevel;
        pin_drive_t  pins;
        logic        ssSync1;
        logic        ssSync2;
        logic        sdiSync1;
        logic        sdiSync2;
        logic        reqSync1;
        logic        reqSync2;
    } mux_state_t;

endpackage

// *** verilog/sensor_output_pin_mux.sv ***
// Output pin assignment, start window and error supervision for the
// bridge sensor conditioner. Assumes configuration words arrive stable
// from nonvolatile storage with a load strobe and a precomputed signature.
`timescale 1ns/1ps
module sensor_output_pin_mux
    import pin_mux_pkg::*;
#(
    parameter int START_CYC = pin_mux_pkg::START_WIN_CYC
) (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    // Nonvolatile configuration
    input  wire logic                  cfgLoad,
    input  wire logic [4:0]            cfgCombo,
    input  wire logic                  cfgStartWinEn,
    input  wire logic [15:0]           cfgSignature,
    input  wire logic [15:0]           calcSignature,
    input  wire logic                  regParityErr,
    // Measurement values and comparator results
    input  wire logic [14:0]           bridgeVal,
    input  wire logic [14:0]           temp1Val,
    input  wire logic [14:0]           temp2Val,
    input  wire pin_mux_pkg::src_sel_t analogSrc,
    input  wire logic                  bridgeAlarmFirst,
    input  wire logic                  bridgeAlarmSecond,
    input  wire logic                  pulseFirst,
    input  wire logic                  pulseSecond,
    // Serial interface core
    input  wire logic                  spiSdo,
    input  wire logic                  i2cSdaOut,
    input  wire logic                  i2cSdaOe,
    input  wire logic                  command_mode,
    // Pin inputs
    input  wire logic                  auxSecondIn,
    input  wire logic                  dataIn,
    input  wire logic                  wireReqIn,
    // Pin drive
    output pin_mux_pkg::pin_drive_t    pins,
    output logic [14:0]                analogLevel,
    // Status
    output logic                       ctrlErrorFlag,
    output logic [7:0]                 serialErrCode,
    output logic                       oneWireMode,
    output logic                       spiSelectN,
    output logic                       spiDataIn,
    output logic                       normal_operation_mode
);

    mux_state_t s_q;
    mux_state_t s_d;

    logic       comboValid;
    logic       isSpi;
    logic       cmdSplit;
    logic [14:0] selVal;
    pin_drive_t drv;

    // ========================================================
    // Combination decode
    always_comb begin
        comboValid = (s_q.combo >= COMBO_MIN) && (s_q.combo <= COMBO_MAX);
        isSpi      = comboValid && (s_q.combo > COMBO_I2C_MAX);
        cmdSplit   = isSpi && (s_q.combo != 5'h13) && (s_q.combo != 5'h16)
                     && (s_q.combo != 5'h19);
        case (analogSrc)
            SRC_TEMP1: selVal = temp1Val;
            SRC_TEMP2: selVal = temp2Val;
            default:   selVal = bridgeVal;
        endcase
    end

    // ========================================================
    // Pin routing; offsets within I2C group repeat every six combinations
    always_comb begin
        logic [4:0] k;
        logic [2:0] aux;
        k   = 5'h00;
        aux = 3'h0;
        drv = '0;
        if (s_q.wireMode) begin
            // Main pin belongs to the one-wire link in the start window
            drv.mainOe = 1'b0;
        end else if (comboValid && !isSpi) begin
            k   = 5'(s_q.combo - COMBO_MIN);
            aux = 3'(k % 5'h06);
            drv.mainAnalogEn = (k >= 5'h06) && (k < 5'h0C);
            drv.mainPulse    = pulseSecond;
            drv.mainOe       = (k >= 5'h0C);
            drv.auxFirst     = (aux == 3'h1 || aux == 3'h3) ? bridgeAlarmFirst
                                                            : pulseFirst;
            drv.auxFirstOe   = (aux != 3'h0) && (aux != 3'h2);
            drv.auxSecond    = bridgeAlarmSecond;
            drv.auxSecondOe  = (aux == 3'h2) || (aux == 3'h3) || (aux == 3'h5);
            drv.dataOut      = i2cSdaOut;
            drv.dataOe       = i2cSdaOe;
        end else if (isSpi) begin
            k = 5'(s_q.combo - 5'h13);
            aux = 3'(k % 5'h03);
            drv.mainAnalogEn = (k >= 5'h03) && (k < 5'h06);
            // Command traffic takes the pulse pin away in every SPI pulse combo (0x19 to 0x1B)
            drv.mainOe       = (k >= 5'h06) && !command_mode;
            drv.mainPulse    = pulseSecond;
            drv.auxSecondOe  = 1'b0;
            if (!cmdSplit || command_mode) begin
                drv.auxFirst   = spiSdo;
                drv.auxFirstOe = 1'b1;
            end else begin
                drv.auxFirst   = (aux == 3'h1) ? bridgeAlarmFirst : pulseFirst;
                drv.auxFirstOe = 1'b1;
            end
        end
        // Diagnostic mode forces main and aux pin levels low; enables and the data pin keep their routing
        if (s_q.state == ST_DIAG) begin
            drv.mainPulse  = 1'b0;
            drv.auxFirst   = 1'b0;
            drv.auxSecond  = 1'b0;
        end
    end

    // ========================================================
    // System control sequencing
    always_comb begin
        s_d          = s_q;
        s_d.ssSync1  = auxSecondIn;
        s_d.ssSync2  = s_q.ssSync1;
        s_d.sdiSync1 = dataIn;
        s_d.sdiSync2 = s_q.sdiSync1;
        s_d.reqSync1 = wireReqIn;
        s_d.reqSync2 = s_q.reqSync1;
        s_d.pins     = drv;
        s_d.anaLevel = selVal;
        case (s_q.state)
            ST_INIT: begin
                if (cfgLoad) begin
                    s_d.combo = cfgCombo;
                    if (cfgSignature != calcSignature) begin
                        s_d.state     = ST_DIAG;
                        s_d.ctrlError = 1'b1;
                        s_d.errCode   = ERR_SIGNATURE;
                    end else if (cfgStartWinEn) begin
                        s_d.state    = ST_START;
                        s_d.wireMode = 1'b1;
                        s_d.winCnt   = '0;
                    end else begin
                        s_d.state = ST_RUN;
                    end
                end
            end
            ST_START: begin
                s_d.winCnt = s_q.winCnt + 21'h000001;
                if (s_q.reqSync2) begin
                    // Valid request: stay on the one-wire link
                    s_d.state = ST_RUN;
                end else if (32'(s_q.winCnt) >= START_CYC - 1) begin
                    s_d.state    = ST_RUN;
                    s_d.wireMode = 1'b0;
                end
            end
            ST_RUN: begin
                if (cfgLoad) begin
                    s_d.state    = ST_INIT;
                    s_d.wireMode = 1'b0;
                end else if (!comboValid) begin
                    s_d.state     = ST_DIAG;
                    s_d.ctrlError = 1'b1;
                    s_d.errCode   = ERR_COMBO;
                end
            end
            ST_DIAG: begin
                s_d.wireMode = 1'b0;
            end
            default: s_d.state = ST_INIT;
        endcase
        // Parity watch runs in every state except diagnostic
        if (regParityErr && s_q.state != ST_DIAG) begin
            s_d.state     = ST_DIAG;
            s_d.ctrlError = 1'b1;
            s_d.errCode   = ERR_PARITY;
        end
        if (s_d.state == ST_DIAG) begin
            // Signature fault pegs high, others low
            s_d.anaLevel = (s_d.errCode == ERR_SIGNATURE) ? ANA_MAX : ANA_MIN;
        end
    end

    // ========================================================
    // State register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_q       <= '0;
            s_q.state <= ST_INIT;
            s_q.combo <= COMBO_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops
    assign pins                  = s_q.pins;
    assign analogLevel           = s_q.anaLevel;
    assign ctrlErrorFlag         = s_q.ctrlError;
    assign serialErrCode         = s_q.errCode;
    assign oneWireMode           = s_q.wireMode;
    assign spiSelectN            = s_q.ssSync2;
    assign spiDataIn             = s_q.sdiSync2;
    assign normal_operation_mode = s_q.state[2]; // One-hot run bit, no decode

endmodule
